// ### inc/status_protect_pkg.sv
// Constants and types for the status and write-protection block
package status_protect_pkg;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STATUS_WRITE_TIME_NS = 1_000_000;

    // ========================================================
    // Instruction codes
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;

    // ========================================================
    // Status byte layout
    localparam int CYCLE_ACTIVE_POS = 0;
    localparam int WRITE_LATCH_POS = 1;
    localparam int GUARD_LSB = 2;
    localparam int GUARD_MSB = 4;
    localparam int LOCK_POS = 7;
    localparam logic [2:0] GUARD_RESET = 3'h0;
    localparam logic [2:0] GUARD_NONE = 3'h0;
    localparam logic [2:0] GUARD_ALL = 3'h7;
    localparam logic LOCK_RESET = 1'b0;

    // ========================================================
    // Framing, counted in whole bytes since select fell
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] LEN_CMD_ONLY = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_ADDR_DONE = 3'h4;
    localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h5;
    localparam logic [2:0] BYTE_CMD = 3'h0;
    localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;

    // ========================================================
    // Array geometry
    localparam int ADDR_W = 24;
    localparam int SECTOR_LSB = 16;
    localparam int SECTOR_MSB = 21;
    localparam logic [6:0] SECTOR_COUNT = 7'h40;
    localparam logic [6:0] SECTOR_ONE = 7'h01;

    typedef enum logic [1:0] {
        ARRAY_PROGRAM,
        ARRAY_SECTOR_ERASE,
        ARRAY_BULK_ERASE
    } array_op_t;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_STATUS_WRITE,
        CYC_ARRAY
    } cycle_state_t;

endpackage

// ### hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ========================================================
    // Chain; first stage feeds only the second
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ========================================================
    // A change counts once stages two and three agree
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_o <= RESET_LEVEL;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end

    assign rise_o = (s2_q == s3_q) && s3_q && !level_o;
    assign fall_o = (s2_q == s3_q) && !s3_q && level_o;

endmodule

// ### hdl/cycle_timer.sv
// Self-timed cycle counter: busy from start until a one-cycle done
`timescale 1ns/1ps
module cycle_timer #(
    parameter int unsigned CYCLES = 100_000
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    logic [31:0] count_q;

    // ========================================================
    // Counter; a start while busy is ignored
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= 32'h0000_0000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (busy_o) begin
                if (count_q == 32'h0000_0001) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                count_q <= count_q - 32'h0000_0001;
            end else if (start_i) begin
                busy_o <= 1'b1;
                count_q <= CYCLES;
            end
        end
    end

endmodule

// ### hdl/status_protect_logic.sv
// Status byte, write latch and protection gating of a serial flash
`timescale 1ns/1ps
module status_protect_logic #(
    parameter int unsigned STATUS_WRITE_CYCLES =
        (status_protect_pkg::STATUS_WRITE_TIME_NS
        + status_protect_pkg::CLK_PERIOD_NS - 1)
        / status_protect_pkg::CLK_PERIOD_NS
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic select_b_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic write_protect_b_i,
    input wire logic array_done_i,
    output logic miso_o,
    output logic miso_oe_b_o,
    output logic array_go_o,
    output status_protect_pkg::array_op_t array_op_o,
    output logic [23:0] array_addr_o,
    output logic hardware_lock_mode_o
);

    // ========================================================
    // Pin synchronisers
    logic sel_b_lvl;
    logic sel_rise;
    logic sel_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic mosi_lvl;
    logic wp_b_lvl;

    pin_sync #(.RESET_LEVEL(1'b1)) u_sel_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(select_b_i),
        .level_o(sel_b_lvl),
        .rise_o(sel_rise),
        .fall_o(sel_fall)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sclk_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(sclk_i),
        .level_o(),
        .rise_o(sclk_rise),
        .fall_o(sclk_fall)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_mosi_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(mosi_i),
        .level_o(mosi_lvl),
        .rise_o(),
        .fall_o()
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_wp_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(write_protect_b_i),
        .level_o(wp_b_lvl),
        .rise_o(),
        .fall_o()
    );

    // ========================================================
    // Status state
    logic write_latch_flag_q;
    logic status_lock_bit_q;
    logic [2:0] area_guard_q;
    logic [7:0] pending_status_q;
    status_protect_pkg::cycle_state_t cycle_q;
    logic cycle_active_flag;
    logic hw_lock;
    logic [7:0] status_byte;

    assign cycle_active_flag = (cycle_q != status_protect_pkg::CYC_IDLE);
    // Lock follows both levels, so the order of bit and pin is irrelevant
    assign hw_lock = status_lock_bit_q && !wp_b_lvl;

    // Reserved positions tie to zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[status_protect_pkg::CYCLE_ACTIVE_POS] = cycle_active_flag;
        status_byte[status_protect_pkg::WRITE_LATCH_POS] = write_latch_flag_q;
        status_byte[status_protect_pkg::GUARD_MSB:status_protect_pkg::GUARD_LSB] =
            area_guard_q;
        status_byte[status_protect_pkg::LOCK_POS] = status_lock_bit_q;
    end

    // ========================================================
    // Serial shifter, most significant bit first
    logic [2:0] bit_idx_q;
    logic [2:0] byte_cnt_q;
    logic [31:0] shift_q;
    logic [7:0] cmd_q;
    logic [23:0] addr_q;
    logic [31:0] shift_next;

    assign shift_next = {shift_q[30:0], mosi_lvl};

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_idx_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q <= 32'h0000_0000;
        end else if (sel_fall) begin
            bit_idx_q <= status_protect_pkg::FIRST_BIT;
            byte_cnt_q <= status_protect_pkg::BYTE_CMD;
        end else if (!sel_b_lvl && sclk_rise) begin
            shift_q <= shift_next;
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == status_protect_pkg::LAST_BIT &&
                byte_cnt_q != status_protect_pkg::BYTE_CNT_MAX) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // Command and address captured on the last bit of their bytes
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_q <= 8'h00;
            addr_q <= 24'h00_0000;
        end else if (!sel_b_lvl && sclk_rise &&
                     bit_idx_q == status_protect_pkg::LAST_BIT) begin
            if (byte_cnt_q == status_protect_pkg::BYTE_CMD) begin
                cmd_q <= shift_next[7:0];
            end
            if (byte_cnt_q == status_protect_pkg::BYTE_ADDR_LAST) begin
                addr_q <= shift_next[23:0];
            end
        end
    end

    // ========================================================
    // Status output; reads are answered even while busy
    logic reading;
    logic [7:0] out_byte_q;

    assign reading = (cmd_q == status_protect_pkg::STATUS_READ_CMD) &&
        (byte_cnt_q != status_protect_pkg::BYTE_CMD);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            miso_o <= 1'b0;
            miso_oe_b_o <= 1'b1;
            out_byte_q <= 8'h00;
        end else if (sel_b_lvl || sel_rise) begin
            miso_oe_b_o <= 1'b1;
        end else if (sclk_fall && reading) begin
            miso_oe_b_o <= 1'b0;
            // Fresh snapshot each byte so the host sees the flag change
            if (bit_idx_q == status_protect_pkg::FIRST_BIT) begin
                out_byte_q <= status_byte;
                miso_o <= status_byte[status_protect_pkg::LAST_BIT];
            end else begin
                miso_o <= out_byte_q[status_protect_pkg::LAST_BIT - bit_idx_q];
            end
        end
    end

    // ========================================================
    // Decode at select rise; only whole bytes count
    logic on_boundary;
    logic can_write;
    logic status_write_cmd_ok;
    logic be_ok;
    logic se_ok;
    logic pp_ok;
    logic se_guarded;
    logic pp_guarded;

    // Guarded region grows from the top sector down
    function automatic logic guarded(input logic [2:0] g, input logic [23:0] a);
        logic [6:0] lowest;
        lowest = status_protect_pkg::SECTOR_COUNT -
            (status_protect_pkg::SECTOR_ONE << (g - 3'h1));
        if (g == status_protect_pkg::GUARD_NONE) begin
            return 1'b0;
        end
        if (g == status_protect_pkg::GUARD_ALL) begin
            return 1'b1;
        end
        return {1'b0, a[status_protect_pkg::SECTOR_MSB:status_protect_pkg::SECTOR_LSB]}
            >= lowest;
    endfunction

    assign se_guarded = guarded(area_guard_q, shift_q[23:0]);
    assign pp_guarded = guarded(area_guard_q, addr_q);
    assign on_boundary = (bit_idx_q == status_protect_pkg::FIRST_BIT);
    // A cycle in flight refuses everything except a status read
    assign can_write = sel_rise && on_boundary && !cycle_active_flag &&
        write_latch_flag_q;

    assign status_write_cmd_ok = can_write &&
        cmd_q == status_protect_pkg::STATUS_WRITE_CMD &&
        byte_cnt_q == status_protect_pkg::LEN_STATUS_WRITE &&
        !hw_lock;
    assign be_ok = can_write &&
        cmd_q == status_protect_pkg::BULK_ERASE_CMD &&
        byte_cnt_q == status_protect_pkg::LEN_CMD_ONLY &&
        area_guard_q == status_protect_pkg::GUARD_NONE;
    assign se_ok = can_write &&
        cmd_q == status_protect_pkg::SECTOR_ERASE_CMD &&
        byte_cnt_q == status_protect_pkg::LEN_ADDR_DONE &&
        !se_guarded;
    assign pp_ok = can_write &&
        cmd_q == status_protect_pkg::PAGE_PROGRAM_CMD &&
        byte_cnt_q == status_protect_pkg::LEN_PROGRAM_MIN &&
        !pp_guarded;

    // ========================================================
    // Status-write timer
    logic wsr_busy;
    logic wsr_done;

    cycle_timer #(.CYCLES(STATUS_WRITE_CYCLES)) u_wsr_timer (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .start_i(status_write_cmd_ok),
        .busy_o(wsr_busy),
        .done_o(wsr_done)
    );

    // ========================================================
    // Cycle tracking
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cycle_q <= status_protect_pkg::CYC_IDLE;
        end else begin
            unique case (cycle_q)
                status_protect_pkg::CYC_IDLE: begin
                    if (status_write_cmd_ok) begin
                        cycle_q <= status_protect_pkg::CYC_STATUS_WRITE;
                    end else if (be_ok || se_ok || pp_ok) begin
                        cycle_q <= status_protect_pkg::CYC_ARRAY;
                    end
                end
                status_protect_pkg::CYC_STATUS_WRITE: begin
                    if (wsr_done) begin
                        cycle_q <= status_protect_pkg::CYC_IDLE;
                    end
                end
                status_protect_pkg::CYC_ARRAY: begin
                    if (array_done_i) begin
                        cycle_q <= status_protect_pkg::CYC_IDLE;
                    end
                end
                default: begin
                    cycle_q <= status_protect_pkg::CYC_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Write-enable latch
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            write_latch_flag_q <= 1'b0;
        end else if ((cycle_q == status_protect_pkg::CYC_STATUS_WRITE && wsr_done) ||
                     (cycle_q == status_protect_pkg::CYC_ARRAY && array_done_i)) begin
            write_latch_flag_q <= 1'b0;
        end else if (sel_rise && on_boundary && !cycle_active_flag &&
                     byte_cnt_q == status_protect_pkg::LEN_CMD_ONLY) begin
            if (cmd_q == status_protect_pkg::WRITE_ENABLE_CMD) begin
                write_latch_flag_q <= 1'b1;
            end else if (cmd_q == status_protect_pkg::WRITE_DISABLE_CMD) begin
                write_latch_flag_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // Persistent protection bits, written only at update end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pending_status_q <= 8'h00;
        end else if (status_write_cmd_ok) begin
            pending_status_q <= shift_q[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_lock_bit_q <= status_protect_pkg::LOCK_RESET;
            area_guard_q <= status_protect_pkg::GUARD_RESET;
        end else if (cycle_q == status_protect_pkg::CYC_STATUS_WRITE && wsr_done) begin
            // Latch, flag and reserved positions are not taken
            status_lock_bit_q <= pending_status_q[status_protect_pkg::LOCK_POS];
            area_guard_q <= pending_status_q[status_protect_pkg::GUARD_MSB:
                status_protect_pkg::GUARD_LSB];
        end
    end

    // ========================================================
    // Array launch; datapath lives outside
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            array_go_o <= 1'b0;
            array_op_o <= status_protect_pkg::ARRAY_PROGRAM;
            array_addr_o <= 24'h00_0000;
        end else begin
            array_go_o <= be_ok || se_ok || pp_ok;
            if (be_ok) begin
                array_op_o <= status_protect_pkg::ARRAY_BULK_ERASE;
            end else if (se_ok) begin
                array_op_o <= status_protect_pkg::ARRAY_SECTOR_ERASE;
                array_addr_o <= shift_q[23:0];
            end else if (pp_ok) begin
                array_op_o <= status_protect_pkg::ARRAY_PROGRAM;
                array_addr_o <= addr_q;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hardware_lock_mode_o <= 1'b0;
        end else begin
            hardware_lock_mode_o <= hw_lock;
        end
    end

endmodule

// ### sim/status_protect_monitor.sv
// Port checker of the status and write-protection block
`timescale 1ns/1ps
module status_protect_monitor #(
    parameter int unsigned STATUS_WRITE_CYCLES = 100_000
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic select_b_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic write_protect_b_i,
    input wire logic array_done_i,
    input wire logic miso_o,
    input wire logic miso_oe_b_o,
    input wire logic array_go_o,
    input wire status_protect_pkg::array_op_t array_op_o,
    input wire logic [23:0] array_addr_o,
    input wire logic hardware_lock_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // ========================================
    // Sequences
    sequence sel_high_run;
        select_b_i [*6];
    endsequence
    sequence wp_high_run;
        write_protect_b_i [*6];
    endsequence
    // ========================================
    // Assertions
    oe_stop_a: assert property (sel_high_run |-> miso_oe_b_o)
        else $error("output driven while deselected");
    oe_start_a: assert property ($fell(miso_oe_b_o) |-> !select_b_i)
        else $error("output enabled outside a frame");
    go_after_sel_a: assert property (array_go_o |-> select_b_i && $past(select_b_i, 2))
        else $error("launch before select rose");
    go_lone_a: assert property (array_go_o |=> !array_go_o [*4])
        else $error("launch pulse repeated");
    addr_held_a: assert property (
        $changed(array_addr_o) || $changed(array_op_o) |-> array_go_o)
        else $error("target changed without launch");
    lock_exit_a: assert property (wp_high_run |-> !hardware_lock_mode_o)
        else $error("lock mode with pin high");
    lock_rise_a: assert property ($rose(hardware_lock_mode_o)
        |-> !write_protect_b_i && !$past(write_protect_b_i, 2))
        else $error("lock mode entered with pin high");
    lock_hold_a: assert property ($fell(hardware_lock_mode_o)
        |-> $past(write_protect_b_i, 2))
        else $error("lock mode left with pin low");
endmodule

bind status_protect_logic status_protect_monitor #(
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) mon_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .select_b_i(select_b_i), .sclk_i(sclk_i),
    .mosi_i(mosi_i), .write_protect_b_i(write_protect_b_i), .array_done_i(array_done_i),
    .miso_o(miso_o), .miso_oe_b_o(miso_oe_b_o), .array_go_o(array_go_o),
    .array_op_o(array_op_o), .array_addr_o(array_addr_o),
    .hardware_lock_mode_o(hardware_lock_mode_o));

// ### sim/spi_host_model.sv
// SPI host model driving select, clock and data of the block
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clock_i,
    input wire logic miso_i,
    input wire logic miso_oe_b_i,
    output logic select_b_o,
    output logic sclk_o,
    output logic mosi_o
);
    // ========================================
    // Idle: clock stands low between frames
    initial begin
        select_b_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // ========================================
    // One frame; tx left aligned, last byte received returned
    task automatic frame(input logic [39:0] tx, input int n, output logic [7:0] rx);
        logic [39:0] sh;
        sh = tx;
        rx = 8'h00;
        select_b_o = 1'b0;
        repeat (4) @(negedge clock_i);
        for (int i = 0; i < n; i++) begin
            mosi_o = (i < 40) ? sh[39] : ~mosi_o;
            sh = sh << 1;
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clock_i);
            // Sampled late: pin synchronisers delay the answer
            rx = {rx[6:0], miso_oe_b_i ? 1'bx : miso_i};
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clock_i);
        select_b_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (12) @(negedge clock_i);
    endtask
endmodule

// ### sim/status_protect_logic_tb_top.sv
// Self-checking bench of the status and write-protection block
`timescale 1ns/1ps
module status_protect_logic_tb_top;
    // ========================================
    // Signals
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic wp_b = 1'b1;
    logic done = 1'b0;
    logic sel_b, sclk, mosi, miso, oe_b, go, lock;
    status_protect_pkg::array_op_t op;
    logic [23:0] addr;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int gos = 0;
    always #5 clock = ~clock;
    spi_host_model host_u (.clock_i(clock), .miso_i(miso), .miso_oe_b_i(oe_b),
        .select_b_o(sel_b), .sclk_o(sclk), .mosi_o(mosi));
    // Short update time keeps the run brief
    status_protect_logic #(.STATUS_WRITE_CYCLES(400)) dut_u (.clock_i(clock),
        .rst_b_i(rst_b), .select_b_i(sel_b), .sclk_i(sclk), .mosi_i(mosi),
        .write_protect_b_i(wp_b), .array_done_i(done), .miso_o(miso), .miso_oe_b_o(oe_b),
        .array_go_o(go), .array_op_o(op), .array_addr_o(addr), .hardware_lock_mode_o(lock));
    always @(posedge clock) begin
        cyc++;
        if (go === 1'b1) begin
            gos++;
        end
        if (cyc == 80000) begin
            errors++;
            results();
        end
    end
    // ========================================
    // Helpers
    task automatic results();
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_word(input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic send(input logic [39:0] tx, input int n);
        logic [7:0] r;
        host_u.frame(tx, n, r);
    endtask
    task automatic write_enable_cmd();
        send({status_protect_pkg::WRITE_ENABLE_CMD, 32'h0000_0000}, 8);
    endtask
    task automatic status_write_cmd(input logic [7:0] d);
        send({status_protect_pkg::STATUS_WRITE_CMD, d, 24'h00_0000}, 16);
    endtask
    task automatic stat(input logic [7:0] e);
        logic [7:0] s;
        host_u.frame({status_protect_pkg::STATUS_READ_CMD, 32'h0000_0000}, 24, s);
        chk_byte(e, s);
    endtask
    task automatic idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 10 && s[0] !== 1'b0; i++) begin
            host_u.frame({status_protect_pkg::STATUS_READ_CMD, 32'h0000_0000}, 16, s);
        end
    endtask
    task automatic arr(input logic [39:0] tx, input int n, input logic hit,
            input status_protect_pkg::array_op_t o);
        int g;
        g = gos;
        write_enable_cmd();
        send(tx, n);
        chk_word(24'(g + int'(hit)), 24'(gos));
        if (hit) begin
            chk_word({22'h0, o}, {22'h0, op});
            if (o != status_protect_pkg::ARRAY_BULK_ERASE) begin
                chk_word(tx[31:8], addr);
            end
        end
    endtask
    task automatic end_op();
        done = 1'b1;
        @(negedge clock);
        done = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        stat(8'h00);
        chk_word(24'h00_0000, {23'h0, lock});
        chk_word(24'h00_0001, {23'h0, oe_b});
    endtask
    task automatic t_write();
        status_write_cmd(8'h9C);
        stat(8'h00);
        write_enable_cmd();
        stat(8'h02);
        send({status_protect_pkg::STATUS_WRITE_CMD, 8'h9C, 24'h00_0000}, 12);
        stat(8'h02);
        status_write_cmd(8'hFF);
        stat(8'h03);
        idle();
        stat(8'h9C);
    endtask
    task automatic t_guard();
        arr({status_protect_pkg::BULK_ERASE_CMD, 32'h0}, 8, 1'b0,
            status_protect_pkg::ARRAY_BULK_ERASE);
        stat(8'h9E);
        arr({status_protect_pkg::SECTOR_ERASE_CMD, 32'h0}, 32, 1'b0,
            status_protect_pkg::ARRAY_SECTOR_ERASE);
        status_write_cmd(8'h84);
        idle();
        stat(8'h84);
        arr({status_protect_pkg::SECTOR_ERASE_CMD, 32'h3F00_0000}, 32, 1'b0,
            status_protect_pkg::ARRAY_SECTOR_ERASE);
        arr({status_protect_pkg::SECTOR_ERASE_CMD, 32'h0}, 32, 1'b1,
            status_protect_pkg::ARRAY_SECTOR_ERASE);
        stat(8'h87);
        end_op();
        stat(8'h84);
        arr({status_protect_pkg::PAGE_PROGRAM_CMD, 32'h0010_00A5}, 40, 1'b1,
            status_protect_pkg::ARRAY_PROGRAM);
        end_op();
    endtask
    task automatic t_lock();
        wp_b = 1'b0;
        repeat (8) @(negedge clock);
        chk_word(24'h00_0001, {23'h0, lock});
        write_enable_cmd();
        status_write_cmd(8'h00);
        idle();
        stat(8'h86);
        wp_b = 1'b1;
        repeat (8) @(negedge clock);
        chk_word(24'h00_0000, {23'h0, lock});
        status_write_cmd(8'h00);
        idle();
        stat(8'h00);
        wp_b = 1'b0;
        write_enable_cmd();
        status_write_cmd(8'h80);
        idle();
        stat(8'h80);
        chk_word(24'h00_0001, {23'h0, lock});
        wp_b = 1'b1;
        arr({status_protect_pkg::BULK_ERASE_CMD, 32'h0}, 8, 1'b1,
            status_protect_pkg::ARRAY_BULK_ERASE);
        end_op();
        stat(8'h80);
        write_enable_cmd();
        stat(8'h82);
        send({status_protect_pkg::WRITE_DISABLE_CMD, 32'h0}, 8);
        stat(8'h80);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_write();
        t_guard();
        t_lock();
        results();
    end
endmodule
